// ---- hw/mbx_defines.svh ----
`ifndef MBX_DEFINES_SVH
`define MBX_DEFINES_SVH

// Register byte offsets
`define MBX_OFS_CTRL    8'h00
`define MBX_OFS_ADDR    8'h04
`define MBX_OFS_WDLO    8'h08
`define MBX_OFS_WDHI    8'h0c
`define MBX_OFS_RDLO    8'h10
`define MBX_OFS_RDHI    8'h14
`define MBX_OFS_STAT    8'h18

// Control fields
`define MBX_CTRL_START  0
`define MBX_CTRL_WRITE  1
`define MBX_CTRL_SEM    2
`define MBX_CTRL_MASTER 3
`define MBX_CTRL_BUSYHI 4
`define MBX_CTRL_BE_LSB 8
`define MBX_CTRL_RST    32'h0000_0018

// Status fields
`define MBX_STAT_ACTIVE 0
`define MBX_STAT_DONE   1
`define MBX_STAT_INT    2
`define MBX_STAT_BUSY   3
`define MBX_STAT_STALL  4

// Timing
`define MBX_CLK_NS      50
`define MBX_APS_NS      5
`define MBX_STRB_NS     15
`define MBX_SETUP_CYC   ((`MBX_APS_NS + `MBX_CLK_NS - 1) / `MBX_CLK_NS)
`define MBX_STRB_CYC    ((`MBX_STRB_NS + `MBX_CLK_NS - 1) / `MBX_CLK_NS)

`endif

// ---- hw/mbx_pkg.sv ----
package mbx_pkg;

  // Pins driven toward the memory port
  typedef struct packed {
    logic [15:0] addr;
    logic        ce_n;
    logic        token_space_select_n;
    logic        rw_n;
    logic        oe_n;
    logic [3:0]  byte_lane_enable_n;
    logic [35:0] dq_out;
    logic        dq_oe;
    logic        ms_sel;
    logic        busy_out;
    logic        busy_oe;
  } mbx_pins_out_s;

  // Pins sampled from the memory port
  typedef struct packed {
    logic [35:0] dq_in;
    logic        int_n;
    logic        busy_n;
  } mbx_pins_in_s;

  typedef enum logic [3:0] {
    MBX_IDLE   = 4'b0001,
    MBX_SETUP  = 4'b0010,
    MBX_STROBE = 4'b0100,
    MBX_RECOV  = 4'b1000
  } mbx_state_e;

endpackage

// ---- hw/mbx_port_ctrl.sv ----
`timescale 1ns/10ps
`include "mbx_defines.svh"

module mbx_port_ctrl (
  input  wire logic                   hclk,      // Bus clock, 20 MHz
  input  wire logic                   hresetn,   // Async reset, active low
  input  wire logic                   hsel,      // Slave select
  input  wire logic [31:0]            haddr,     // Byte address
  input  wire logic [1:0]             htrans,    // Transfer type
  input  wire logic                   hwrite,    // Write when high
  input  wire logic [2:0]             hsize,     // Transfer size
  input  wire logic [31:0]            hwdata,    // Write data
  input  wire logic                   hready,    // Bus ready
  output logic      [31:0]            hrdata,    // Read data
  output logic                        hreadyout, // Always ready
  output logic                        hresp,     // Always OKAY
  output mbx_pkg::mbx_pins_out_s      pins_o,    // Toward memory port
  input  wire mbx_pkg::mbx_pins_in_s  pins_i     // From memory port
);
  import mbx_pkg::*;

  localparam logic [3:0] SETUP_CYC = 4'(`MBX_SETUP_CYC);
  localparam logic [3:0] STRB_CYC  = 4'(`MBX_STRB_CYC);

  logic [31:0] ctrl_q;
  logic [15:0] addr_q;
  logic [35:0] wdata_q;
  logic [35:0] rdata_q;
  logic        done_q;
  logic        stall_q;
  logic [7:0]  ofs_q;
  logic        wr_q;
  mbx_state_e  state_q;
  mbx_state_e  state_d;
  logic [3:0]  cnt_q;
  logic        op_wr_q;
  logic        op_sem_q;

  // Address phase capture
  wire         take     = hsel & htrans[1] & hready;
  wire         bus_wr   = wr_q;
  wire         wr_ctrl  = bus_wr & (ofs_q == `MBX_OFS_CTRL);
  wire         wr_stat  = bus_wr & (ofs_q == `MBX_OFS_STAT);
  wire         start    = wr_ctrl & hwdata[`MBX_CTRL_START] & (state_q == MBX_IDLE);
  wire         master   = ctrl_q[`MBX_CTRL_MASTER];
  wire         cnt_end  = (cnt_q == 4'h1);
  // A non-semaphore write may not start while the master holds our busy low
  wire         blocked  = op_wr_q & ~op_sem_q & master & ~pins_i.busy_n;
  wire         done_set = (state_q == MBX_RECOV);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ofs_q <= 8'h00;
      wr_q  <= 1'b0;
    end else begin
      ofs_q <= take ? haddr[7:0] : ofs_q;
      wr_q  <= take & hwrite;
    end
  end

  // Register writes; start bit is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= `MBX_CTRL_RST;
      addr_q  <= 16'h0000;
      wdata_q <= 36'h0_0000_0000;
    end else if (bus_wr) begin
      if (ofs_q == `MBX_OFS_CTRL)
        ctrl_q <= {hwdata[31:1], 1'b0};
      if (ofs_q == `MBX_OFS_ADDR && state_q == MBX_IDLE)
        addr_q <= hwdata[15:0];
      if (ofs_q == `MBX_OFS_WDLO && state_q == MBX_IDLE)
        wdata_q[31:0] <= hwdata;
      if (ofs_q == `MBX_OFS_WDHI && state_q == MBX_IDLE)
        wdata_q[35:32] <= hwdata[3:0];
    end
  end

  // Sticky flags: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q  <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      done_q  <= done_set | (done_q & ~(wr_stat & hwdata[`MBX_STAT_DONE]));
      stall_q <= ((state_q == MBX_SETUP) & blocked) |
                 (stall_q & ~(wr_stat & hwdata[`MBX_STAT_STALL]));
    end
  end

  // Access sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MBX_IDLE:   if (start) state_d = MBX_SETUP;
      MBX_SETUP:  if (cnt_end && !blocked) state_d = MBX_STROBE;
      MBX_STROBE: if (cnt_end) state_d = MBX_RECOV;
      MBX_RECOV:  state_d = MBX_IDLE;
      default:    state_d = MBX_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= MBX_IDLE;
      cnt_q    <= 4'h0;
      op_wr_q  <= 1'b0;
      op_sem_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        op_wr_q  <= hwdata[`MBX_CTRL_WRITE];
        op_sem_q <= hwdata[`MBX_CTRL_SEM];
        cnt_q    <= SETUP_CYC;
      end else if (state_q == MBX_SETUP && state_d == MBX_STROBE) begin
        cnt_q <= STRB_CYC;
      end else if (cnt_q > 4'h1) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // Read data caught at strobe end; semaphore reads keep only bit zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rdata_q <= 36'h0_0000_0000;
    else if (state_q == MBX_STROBE && cnt_end && !op_wr_q)
      rdata_q <= op_sem_q ? {35'h0, pins_i.dq_in[0]} : pins_i.dq_in;
  end

  // Pin drive: space select chosen once for the whole access
  wire in_acc = (state_q != MBX_IDLE);
  wire sem_on = in_acc & op_sem_q;
  assign pins_o.addr                 = addr_q;
  assign pins_o.ce_n                 = ~(in_acc & ~op_sem_q);
  assign pins_o.token_space_select_n = ~sem_on;
  assign pins_o.rw_n                 = ~((state_q == MBX_STROBE) & op_wr_q);
  assign pins_o.oe_n                 = ~((state_q == MBX_STROBE) & ~op_wr_q);
  assign pins_o.byte_lane_enable_n   = ctrl_q[`MBX_CTRL_BE_LSB +: 4];
  // Semaphore writes carry the token value on bit zero only
  assign pins_o.dq_out = op_sem_q ? {35'h0, wdata_q[0]} : wdata_q;
  assign pins_o.dq_oe  = in_acc & op_wr_q;
  // Master drives busy itself; slave inputs are held high for free writes
  assign pins_o.ms_sel   = master;
  assign pins_o.busy_out = ctrl_q[`MBX_CTRL_BUSYHI];
  assign pins_o.busy_oe  = ~master;

  // Register readback; mailbox flag level lets firmware clear it at power-up
  wire [31:0] stat = {27'h0, stall_q, pins_i.busy_n, pins_i.int_n, done_q, in_acc};
  assign hrdata = (ofs_q == `MBX_OFS_CTRL) ? ctrl_q :
                  (ofs_q == `MBX_OFS_ADDR) ? {16'h0, addr_q} :
                  (ofs_q == `MBX_OFS_WDLO) ? wdata_q[31:0] :
                  (ofs_q == `MBX_OFS_WDHI) ? {28'h0, wdata_q[35:32]} :
                  (ofs_q == `MBX_OFS_RDLO) ? rdata_q[31:0] :
                  (ofs_q == `MBX_OFS_RDHI) ? {28'h0, rdata_q[35:32]} :
                  (ofs_q == `MBX_OFS_STAT) ? stat : 32'h0;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  a_sem_no_ce: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins_o.token_space_select_n |-> pins_o.ce_n)
    else $error("Chip enable low during semaphore access");

  a_sem_held: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(pins_o.token_space_select_n) |=> !pins_o.token_space_select_n [*2])
    else $error("Semaphore select dropped too early");

  a_setup_first: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(pins_o.rw_n) |-> $stable(pins_o.addr) && $past(state_q) == MBX_SETUP
      && ($past(pins_o.ce_n) == pins_o.ce_n))
    else $error("Write strobe without settled address");

  a_no_wr_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == MBX_SETUP && blocked) |=> pins_o.rw_n)
    else $error("Write strobe while busy low");

  a_slave_busy_hi: assert property (@(posedge hclk) disable iff (!hresetn)
    (!master && ctrl_q[`MBX_CTRL_BUSYHI]) |-> pins_o.busy_oe && pins_o.busy_out)
    else $error("Slave busy input not held high");

  a_master_nodrv: assert property (@(posedge hclk) disable iff (!hresetn)
    master |-> !pins_o.busy_oe)
    else $error("Busy driven against master output");

  a_done_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    start |-> ##[3:1000] done_q)
    else $error("Access never completed");

  a_addr_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_acc && $past(in_acc)) |-> $stable(pins_o.addr))
    else $error("Address moved during an access");

  a_strobe_ends: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(pins_o.rw_n) |=> pins_o.rw_n && (!pins_o.ce_n || !pins_o.token_space_select_n))
    else $error("Enable released with the write strobe");

  a_sem_bit_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pins_o.token_space_select_n && pins_o.dq_oe) |-> (pins_o.dq_out[35:1] == 35'h0))
    else $error("Semaphore write drives upper data bits");

  a_read_no_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins_o.oe_n |-> !pins_o.dq_oe)
    else $error("Data driven during a read");

endmodule // mbx_port_ctrl

// ---- testbench/mbx_dev_model.sv ----
`timescale 1ns/10ps
// Memory device seen from its left port; the right port is worked by tasks
module mbx_dev_model (
  input  wire mbx_pkg::mbx_pins_out_s ctl,  // Controller pins
  output mbx_pkg::mbx_pins_in_s       rsp   // Device answers
);
  import mbx_pkg::*;
  logic [35:0] mem [0:65535];
  logic [7:0]  req_l = 8'hff;
  logic [7:0]  req_r = 8'hff;
  logic [1:0]  own [0:7] = '{default: 2'h0};  // 0 free, 1 left, 2 right
  logic        int_l_n = 1'b0;  // Mailbox flags wake up set on purpose
  logic        int_r_n = 1'b0;
  logic        r_on = 1'b0;
  logic [15:0] r_addr = 16'h0;
  logic        tok_lat;
  logic        last = 1'b0;
  logic        arb_n;
  // Right port already holds the location, so only the left side is told busy
  assign arb_n = !(r_on && !ctl.ce_n && ctl.addr == r_addr);
  assign rsp.busy_n = ctl.ms_sel ? arb_n : (!ctl.busy_oe | ctl.busy_out);
  assign rsp.int_n = int_l_n;
  // Released data lines flip on every read so stale values never pass
  assign rsp.dq_in = ctl.oe_n ? {36{last}} :
                     ctl.ce_n ? {36{tok_lat}} : mem[ctl.addr];
  always @(posedge ctl.oe_n) last = ~last;
  // Writes land at the end of the strobe; a low busy gates all but token writes
  always @(posedge ctl.rw_n) begin
    if (!ctl.ce_n && rsp.busy_n) begin
      mem[ctl.addr] = ctl.dq_out;
      if (ctl.addr == 16'hffff) int_r_n = 1'b0;
    end else if (!ctl.token_space_select_n && ctl.ce_n) begin
      tok_wr(0, ctl.addr[2:0], ctl.dq_out[0]);
    end
  end
  // Token value is frozen while a read is open
  always @(negedge (ctl.token_space_select_n | ctl.oe_n))
    tok_lat = own[ctl.addr[2:0]] != 2'h1;
  always @(negedge ctl.oe_n)
    if (!ctl.ce_n && ctl.addr == 16'hfffe) int_l_n = 1'b1;
  task automatic tok_wr(input int s, input logic [2:0] i, input logic v);
    if (s == 0) req_l[i] = v;
    else req_r[i] = v;
    if (v && own[i] == s + 1) own[i] = 2'h0;
    // A pending request takes over at once; a true tie goes left
    if (own[i] == 2'h0)
      own[i] = !req_l[i] ? 2'h1 : !req_r[i] ? 2'h2 : 2'h0;
  endtask
  task automatic r_write(input logic [15:0] a, input logic [35:0] d);
    mem[a] = d;
    if (a == 16'hfffe) int_l_n = 1'b0;
  endtask
  task automatic r_read(input logic [15:0] a, output logic [35:0] d);
    d = mem[a];
    if (a == 16'hffff) int_r_n = 1'b1;
  endtask
endmodule  // mbx_dev_model

// ---- testbench/tb_mbx_port_ctrl.sv ----
`timescale 1ns/10ps
module tb_mbx_port_ctrl;
  import mbx_pkg::*;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hwrite = 1'b0;
  logic          hrdy;
  logic          hresp;
  logic [1:0]    htrans = 2'b00;
  logic [31:0]   haddr = 32'h0;
  logic [31:0]   hwdata = 32'h0;
  logic [31:0]   hrdata;
  logic [31:0]   mode = 32'h18;
  logic [31:0]   st;
  logic [35:0]   r;
  mbx_pins_out_s pins_o;
  mbx_pins_in_s  pins_i;
  int            n_errors = 0;
  int            checked = 0;
  int            cyc = 0;
  // Token steps as {right side, value, left reads, right reads}
  logic [3:0]    steps [0:9] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hd, 4'h7, 4'ha, 4'hf, 4'h1, 4'h7};
  always #25 hclk = ~hclk;
  mbx_port_ctrl u_mbx_port_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .pins_o(pins_o), .pins_i(pins_i));
  mbx_dev_model u_mbx_dev_model (.ctl(pins_o), .rsp(pins_i));
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  // One memory-port access; st keeps the status seen before flags are cleared
  task automatic acc(input logic w, input logic s, input logic [15:0] a, input logic [35:0] d);
    logic [31:0] q;
    int n;
    wr(8'h04, {16'h0, a});
    wr(8'h08, d[31:0]);
    wr(8'h0c, {28'h0, d[35:32]});
    wr(8'h00, mode | {29'h0, s, w, 1'b1});
    n = 0;
    st = 32'h0;
    while (st[1] !== 1'b1 && n < 100) begin
      ahb(1'b0, 8'h18, 32'h0, st);
      n++;
    end
    chk("done seen", 36'(n < 100), 36'h1);
    wr(8'h18, 32'h12);
    ahb(1'b0, 8'h10, 32'h0, q);
    r[31:0] = q;
    ahb(1'b0, 8'h14, 32'h0, q);
    r[35:32] = q[3:0];
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("idle pins", {hresp, pins_o.byte_lane_enable_n, pins_o.dq_oe,
      pins_o.token_space_select_n, pins_o.oe_n, pins_o.rw_n, pins_o.ce_n}, 36'h00f);
    ahb(1'b0, 8'h00, 32'h0, st);
    chk("ctrl reset", st, 36'h18);
    ahb(1'b0, 8'h1c, 32'h0, st);
    chk("unmapped", st, 36'h0);
    // Firmware clears the flag left over from power-up
    acc(1'b0, 1'b0, 16'hfffe, 36'h0);
    chk("left int init", st[2], 36'h1);
    // Far side clears its own flag first, so the set below is really seen
    u_mbx_dev_model.r_read(16'hffff, r);
    chk("right int init", u_mbx_dev_model.int_r_n, 36'h1);
    acc(1'b1, 1'b0, 16'hffff, 36'h9_a5a5_0f0f);
    chk("right int set", u_mbx_dev_model.int_r_n, 36'h0);
    u_mbx_dev_model.r_read(16'hffff, r);
    chk("right mailbox", r, 36'h9_a5a5_0f0f);
    chk("right int clear", u_mbx_dev_model.int_r_n, 36'h1);
    u_mbx_dev_model.r_write(16'hfffe, 36'h6_1234_5678);
    ahb(1'b0, 8'h18, 32'h0, st);
    chk("left int set", st[2], 36'h0);
    acc(1'b0, 1'b0, 16'hfffe, 36'h0);
    chk("left mailbox", r, 36'h6_1234_5678);
    chk("left int clear", st[2], 36'h1);
    // Upper address bits differ between writes and reads of one token
    foreach (steps[i]) begin
      if (steps[i][3]) u_mbx_dev_model.tok_wr(1, 3'h5, steps[i][2]);
      else acc(1'b1, 1'b1, 16'hfff5, {35'h0, steps[i][2]});
      acc(1'b0, 1'b1, 16'h0ad5, 36'h0);
      chk("left token", r, {35'h0, steps[i][1]});
    end
    u_mbx_dev_model.r_write(16'h0100, 36'h0);
    u_mbx_dev_model.r_addr <= 16'h0100;
    u_mbx_dev_model.r_on <= 1'b1;
    fork
      acc(1'b1, 1'b0, 16'h0100, 36'h3_0000_00c3);
      begin
        repeat (30) @(posedge hclk);
        // Still selected but no strobe: the access waits rather than ends
        chk("stalled strobe", {pins_o.ce_n, pins_o.rw_n}, 36'h1);
        chk("stalled write", u_mbx_dev_model.mem[16'h0100], 36'h0);
        u_mbx_dev_model.r_on <= 1'b0;
      end
    join
    chk("stall flag", st[4], 36'h1);
    chk("late write", u_mbx_dev_model.mem[16'h0100], 36'h3_0000_00c3);
    mode = 32'h0;
    u_mbx_dev_model.r_write(16'h0200, 36'ha);
    acc(1'b1, 1'b0, 16'h0200, 36'h5);
    chk("slave pins", {pins_o.ms_sel, pins_o.busy_oe, pins_o.busy_out}, 36'h2);
    chk("slave busy pin", st[3], 36'h0);
    chk("blocked write", u_mbx_dev_model.mem[16'h0200], 36'ha);
    mode = 32'h10;
    acc(1'b1, 1'b0, 16'h0200, 36'h5);
    chk("free busy pin", st[3], 36'h1);
    chk("open write", u_mbx_dev_model.mem[16'h0200], 36'h5);
    give_verdict();
  end
endmodule  // tb_mbx_port_ctrl
